// ===== design/serial_sram_multi_io_slave.sv
// serial sram slave front end: pin sync, command decode, lane shifting
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - chip select high: idle, outputs released
// - sample on rise, drive after fall
// - pause input suspends, sequence kept
// - pause applies while clock low only
// - paused: clock and data ignored
// - pause low floats output at once
// - quad: no pause, pins are lanes
// - dual: lanes 0 and 1 bidirectional
// - eight bit instruction, select held low
// - everything shifted msb first
// - mode bits 7:6 pick burst mode
// - byte mode moves one data byte
// - page mode wraps inside 32 bytes
// - sequential mode rolls over to zero
// - write: command, address, data bytes
// - read streams data, address increments
// - 03h reads, 02h writes array
// - 3bh dual lanes, 38h quad lanes
// - ffh returns to single lane
// - 05h reads, 01h writes mode register
// - dual reads get four dummy clocks
module serial_sram_multi_io_slave
  import sram_slave_pkg::*;
#(
  parameter int AW = ADDR_BITS
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic io_lane0_in,
  output logic io_lane0_out,
  output logic io_lane0_oe_out,
  input wire logic io_lane1_in,
  output logic io_lane1_out,
  output logic io_lane1_oe_out,
  input wire logic io_lane2_in,
  output logic io_lane2_out,
  output logic io_lane2_oe_out,
  input wire logic io_lane3_in,
  output logic io_lane3_out,
  output logic io_lane3_oe_out
);

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [5:0] meta_q;
  logic [5:0] sync_q;
  logic sck_prev_q;

  // two stages on every pin; only sync_q is read by logic
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      // idle pin levels: select high, clock low, lanes and pause high
      // so that no false pause or edge is seen right after reset
      meta_q <= 6'h3d;
      sync_q <= 6'h3d;
      sck_prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= {io_lane3_in, io_lane2_in, io_lane1_in, io_lane0_in, sck_in, cs_n_in};
      sync_q <= meta_q;
      sck_prev_q <= sync_q[1];
    end
  end

  logic cs_s;
  logic sck_s;
  logic [3:0] lanes_s;
  logic hold_n_s;
  assign cs_s = sync_q[0];
  assign sck_s = sync_q[1];
  assign lanes_s = sync_q[5:2];
  assign hold_n_s = lanes_s[3];

  ////////////////////////////////////////////////////////////////////
  // sequencer state

  seq_state_t state_q, state_d;
  lane_mode_t lane_q, lane_d;
  logic [1:0] mode_q, mode_d;
  logic [7:0] cmd_q, cmd_d;
  logic [ADDR_FIELD_BITS-1:0] shift_q, shift_d;
  logic [4:0] cnt_q, cnt_d;
  logic [AW-1:0] addr_q, addr_d;
  logic [7:0] out_q, out_d;
  logic first_q, first_d;
  logic drive_q, drive_d;
  logic paused_q, paused_d;
  logic [3:0] val_q, val_d;
  logic [3:0] oe_q, oe_d;

  sram_mem_if #(.AW(AW)) mem ();

  sram_store #(.AW(AW)) u_store (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .mem(mem)
  );

  logic act_rise;
  logic act_fall;
  logic [4:0] step;
  logic [3:0] in_bits;
  logic [ADDR_FIELD_BITS-1:0] shifted;
  logic [4:0] nbits;
  logic [AW-1:0] next_addr;
  logic [7:0] src_byte;
  logic [7:0] tx_byte;
  logic [3:0] oe_mask;

  // lane width and incoming bits, upper lane carries the higher bit
  always_comb
  begin
    case (lane_q)
      dual_lane_mode:
      begin
        step = 5'h02;
        in_bits = {2'b00, lanes_s[1:0]};
        oe_mask = 4'b0011;
      end
      quad_lane_mode:
      begin
        step = 5'h04;
        in_bits = lanes_s;
        oe_mask = 4'b1111;
      end
      default:
      begin
        step = 5'h01;
        in_bits = {3'b000, lanes_s[0]};
        oe_mask = 4'b0010;
      end
    endcase
  end

  // address step per burst mode; mode 11 behaves as sequential
  always_comb
  begin
    case (mode_q)
      BURST_PAGE: next_addr = {addr_q[AW-1:PAGE_BITS], addr_q[PAGE_BITS-1:0] + 5'h01};
      default: next_addr = addr_q + 1'b1;
    endcase
  end

  assign act_rise = sck_s & ~sck_prev_q & ~paused_q & ~cs_s;
  assign act_fall = ~sck_s & sck_prev_q & ~paused_q & ~cs_s;
  assign shifted = (shift_q << step) | {20'h00000, in_bits};
  assign nbits = cnt_q + step;
  assign src_byte = (state_q == ST_MRR) ? {mode_q, 6'h00} : mem.rdata;

  // next values of the whole sequencer
  always_comb
  begin
    state_d = state_q;
    lane_d = lane_q;
    mode_d = mode_q;
    cmd_d = cmd_q;
    shift_d = shift_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    out_d = out_q;
    first_d = first_q;
    drive_d = drive_q;
    val_d = val_q;
    tx_byte = out_q;
    mem.we = 1'b0;
    mem.addr = addr_q;
    mem.wdata = shifted[7:0];
    if (cs_s)
    begin
      state_d = ST_CMD;
      cnt_d = 5'h00;
      drive_d = 1'b0;
    end
    else if (act_rise && state_q != ST_RDATA && state_q != ST_MRR && state_q != ST_DONE)
    begin
      shift_d = shifted;
      cnt_d = nbits;
      case (state_q)
        ST_CMD:
        begin
          if (nbits == 5'(BYTE_BITS))
          begin
            cnt_d = 5'h00;
            cmd_d = shifted[7:0];
            case (shifted[7:0])
              CMD_READ, CMD_WRITE: state_d = ST_ADDR;
              READ_MODE_REG_CMD: state_d = ST_MRR;
              WRITE_MODE_REG_CMD: state_d = ST_MRW;
              ENTER_DUAL_CMD:
              begin
                lane_d = dual_lane_mode;
                state_d = ST_DONE;
              end
              ENTER_QUAD_CMD:
              begin
                lane_d = quad_lane_mode;
                state_d = ST_DONE;
              end
              EXIT_MULTI_LANE_CMD:
              begin
                lane_d = LANE_SINGLE;
                state_d = ST_DONE;
              end
              default: state_d = ST_DONE;
            endcase
          end
        end
        ST_ADDR:
        begin
          if (nbits == 5'(ADDR_FIELD_BITS))
          begin
            cnt_d = 5'h00;
            addr_d = shifted[AW-1:0];
            first_d = 1'b1;
            if (cmd_q == CMD_READ)
              state_d = (lane_q == dual_lane_mode) ? ST_DUMMY : ST_RDATA;
            else
              state_d = ST_WDATA;
          end
        end
        ST_DUMMY:
        begin
          if (nbits == DUAL_DUMMY_BITS)
          begin
            cnt_d = 5'h00;
            state_d = ST_RDATA;
          end
        end
        ST_WDATA:
        begin
          if (nbits == 5'(BYTE_BITS))
          begin
            cnt_d = 5'h00;
            mem.we = 1'b1;
            addr_d = next_addr;
            if (mode_q == BURST_BYTE)
              state_d = ST_DONE;
          end
        end
        ST_MRW:
        begin
          if (nbits == 5'(BYTE_BITS))
          begin
            cnt_d = 5'h00;
            mode_d = shifted[MODE_FIELD_HI:MODE_FIELD_LO];
            state_d = ST_DONE;
          end
        end
        default: state_d = state_q;
      endcase
    end
    else if (act_fall && (state_q == ST_RDATA || state_q == ST_MRR))
    begin
      if (cnt_q == 5'h00)
        tx_byte = src_byte;
      if (cnt_q == 5'h00 && state_q == ST_RDATA && mode_q == BURST_BYTE && !first_q)
      begin
        state_d = ST_DONE;
        drive_d = 1'b0;
      end
      else
      begin
        if (cnt_q == 5'h00 && state_q == ST_RDATA)
        begin
          addr_d = next_addr;
          first_d = 1'b0;
        end
        drive_d = 1'b1;
        out_d = tx_byte << step;
        cnt_d = (nbits == 5'(BYTE_BITS)) ? 5'h00 : nbits;
        // dual uses lanes 0 and 1
        case (lane_q)
          dual_lane_mode: val_d = {2'b00, tx_byte[7:6]};
          quad_lane_mode: val_d = tx_byte[7:4];
          default: val_d = {2'b00, tx_byte[7], 1'b0};
        endcase
      end
    end
  end

  // pause is taken or released by the pin only while the clock is low; deselect or quad mode clears it at any clock level
  always_comb
  begin
    if (cs_s || lane_q == quad_lane_mode)
      paused_d = 1'b0;
    else if (!sck_s)
      paused_d = ~hold_n_s;
    else
      paused_d = paused_q;
  end

  // enables follow the pause pin directly, not the sck-gated pause
  always_comb
  begin
    if (drive_q && !cs_s && (lane_q == quad_lane_mode || hold_n_s))
      oe_d = oe_mask;
    else
      oe_d = 4'h0;
  end

  // register every sequencer value
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state_q <= ST_CMD;
      lane_q <= LANE_SINGLE;
      mode_q <= MODE_RESET;
      cmd_q <= 8'h00;
      shift_q <= 24'h000000;
      cnt_q <= 5'h00;
      addr_q <= '0;
      out_q <= 8'h00;
      first_q <= 1'b0;
      drive_q <= 1'b0;
      paused_q <= 1'b0;
      val_q <= 4'h0;
      oe_q <= 4'h0;
    end
    else
    begin
      state_q <= state_d;
      lane_q <= lane_d;
      mode_q <= mode_d;
      cmd_q <= cmd_d;
      shift_q <= shift_d;
      cnt_q <= cnt_d;
      addr_q <= addr_d;
      out_q <= out_d;
      first_q <= first_d;
      drive_q <= drive_d;
      paused_q <= paused_d;
      val_q <= val_d;
      oe_q <= oe_d;
    end
  end

  assign io_lane0_out = val_q[0];
  assign io_lane1_out = val_q[1];
  assign io_lane2_out = val_q[2];
  assign io_lane3_out = val_q[3];
  assign io_lane0_oe_out = oe_q[0];
  assign io_lane1_oe_out = oe_q[1];
  assign io_lane2_oe_out = oe_q[2];
  assign io_lane3_oe_out = oe_q[3];

  ////////////////////////////////////////////////////////////////////
  // checks

  property p_desel;
    @(posedge clk_in) disable iff (!nrst_in)
    cs_s |=> (oe_q == 4'h0) && (state_q == ST_CMD);
  endproperty
  a_desel: assert property (p_desel) else $error("outputs driven while deselected");

  property p_hold_float;
    @(posedge clk_in) disable iff (!nrst_in)
    (!hold_n_s && lane_q != quad_lane_mode) |=> !oe_q[1];
  endproperty
  a_hold_float: assert property (p_hold_float) else $error("output not floated on pause");

  property p_paused_still;
    @(posedge clk_in) disable iff (!nrst_in)
    (paused_q && !cs_s) |=> $stable(cnt_q) && $stable(state_q);
  endproperty
  a_paused_still: assert property (p_paused_still) else $error("sequence moved while paused");

  property p_out_on_fall;
    @(posedge clk_in) disable iff (!nrst_in)
    $changed(val_q) |-> $past(~sck_s & sck_prev_q);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("output changed off a falling edge");

  property p_quad_no_pause;
    @(posedge clk_in) disable iff (!nrst_in)
    (lane_q == quad_lane_mode) |=> !paused_q;
  endproperty
  a_quad_no_pause: assert property (p_quad_no_pause) else $error("pause active in quad mode");

  property p_page_wrap;
    @(posedge clk_in) disable iff (!nrst_in)
    (mode_q == BURST_PAGE && addr_d != addr_q && state_q != ST_ADDR)
      |=> addr_q[AW-1:PAGE_BITS] == $past(addr_q[AW-1:PAGE_BITS]);
  endproperty
  a_page_wrap: assert property (p_page_wrap) else $error("page burst left its page");

  property p_seq_inc;
    @(posedge clk_in) disable iff (!nrst_in)
    (mode_q == BURST_SEQ && mem.we) |=> addr_q == $past(addr_q) + 1'b1;
  endproperty
  a_seq_inc: assert property (p_seq_inc) else $error("sequential address not advanced");

  property p_byte_one;
    @(posedge clk_in) disable iff (!nrst_in)
    (mem.we && mode_q == BURST_BYTE && !cs_s) |=> state_q == ST_DONE;
  endproperty
  a_byte_one: assert property (p_byte_one) else $error("byte mode took a second byte");

  property p_addr_cmd;
    @(posedge clk_in) disable iff (!nrst_in)
    (state_q == ST_ADDR) |-> (cmd_q == CMD_READ || cmd_q == CMD_WRITE);
  endproperty
  a_addr_cmd: assert property (p_addr_cmd) else $error("address phase without array command");

  property p_dual_dummy;
    @(posedge clk_in) disable iff (!nrst_in)
    ($rose(state_q == ST_RDATA) && lane_q == dual_lane_mode) |-> $past(state_q) == ST_DUMMY;
  endproperty
  a_dual_dummy: assert property (p_dual_dummy) else $error("dual read skipped dummy byte");

endmodule : serial_sram_multi_io_slave
`default_nettype wire

// ===== design/sram_mem_if.sv
// carrier between the command front end and the byte store
`timescale 1ns/1ps
`default_nettype none
interface sram_mem_if #(parameter int AW = 17);
  logic we;
  logic [AW-1:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output we, output addr, output wdata, input rdata);
  modport store (input we, input addr, input wdata, output rdata);
endinterface : sram_mem_if
`default_nettype wire

// ===== design/sram_slave_pkg.sv
// shared constants and types for the serial sram slave
package sram_slave_pkg;

  // array geometry
  localparam int ADDR_BITS = 17;
  localparam int PAGE_BITS = 5;
  localparam int BYTE_BITS = 8;
  localparam int ADDR_FIELD_BITS = 24;

  // instruction codes
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_WRITE = 8'h02;
  localparam logic [7:0] ENTER_DUAL_CMD = 8'h3b;
  localparam logic [7:0] ENTER_QUAD_CMD = 8'h38;
  localparam logic [7:0] EXIT_MULTI_LANE_CMD = 8'hff;
  localparam logic [7:0] READ_MODE_REG_CMD = 8'h05;
  localparam logic [7:0] WRITE_MODE_REG_CMD = 8'h01;

  // mode register field, bits 7:6
  localparam int MODE_FIELD_HI = 7;
  localparam int MODE_FIELD_LO = 6;
  localparam logic [1:0] BURST_BYTE = 2'h0;
  localparam logic [1:0] BURST_PAGE = 2'h2;
  localparam logic [1:0] BURST_SEQ = 2'h1;
  localparam logic [1:0] MODE_RESET = BURST_SEQ;

  // dummy bits before dual lane read data (four clocks of two bits)
  localparam logic [4:0] DUAL_DUMMY_BITS = 5'h08;

  // lane arrangement
  typedef enum logic [1:0] {
    LANE_SINGLE = 2'b00,
    dual_lane_mode = 2'b01,
    quad_lane_mode = 2'b10
  } lane_mode_t;

  // command sequence states
  typedef enum logic [2:0] {
    ST_CMD = 3'b000,
    ST_ADDR = 3'b001,
    ST_DUMMY = 3'b010,
    ST_WDATA = 3'b011,
    ST_RDATA = 3'b100,
    ST_MRW = 3'b101,
    ST_MRR = 3'b110,
    ST_DONE = 3'b111
  } seq_state_t;

endpackage : sram_slave_pkg

// ===== design/sram_store.sv
// byte store with registered read data
`timescale 1ns/1ps
`default_nettype none
module sram_store #(
  parameter int AW = 17
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  sram_mem_if.store mem
);

  logic [7:0] array_q [0:(1<<AW)-1];
  logic [7:0] rdata_q;

  // array itself is not reset, only the read register
  always_ff @(posedge clk_in)
  begin
    if (mem.we)
      array_q[mem.addr] <= mem.wdata;
  end

  // read data always follows the address one cycle later
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rdata_q <= 8'h00;
    else
      rdata_q <= array_q[mem.addr];
  end

  assign mem.rdata = rdata_q;

endmodule : sram_store
`default_nettype wire

// ===== sim/spi_host_model.sv
// host spi master model that drives the slave's pins
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  input wire logic clk_in,
  input wire logic [3:0] lane_in,
  output logic cs_n_out,
  output logic sck_out,
  output logic [3:0] d_out,
  output logic [3:0] oe_out
);
  // pause level carried on lane 3 outside quad transfers
  logic run;

  // idle bus: deselected, clock low, pause released
  initial
  begin
    run = 1'b1;
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    d_out = 4'hf;
    oe_out = 4'h9;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask : tick

  ////////////////////////////////////////
  // select framing
  // the gap lets the select sync settle before sck moves
  task automatic sel(input logic v);
    tick(1);
    cs_n_out <= v;
    tick(6);
  endtask : sel

  task automatic hold(input logic v);
    tick(1);
    run = v;
    d_out[3] <= v;
    tick(6);
  endtask : hold

  // msb first, w bits a clock
  // data moves with the fall; read bits are taken at the rise
  task automatic xfer(input logic [7:0] tx, input int w, input logic drv,
                      output logic [7:0] rx);
    logic [3:0] c;
    rx = 8'h00;
    for (int b = 8 - w; b >= 0; b -= w)
    begin
      c = 4'(tx >> b);
      d_out <= (w == 4) ? c : (w == 2) ? {run, 1'b1, c[1:0]} : {run, 2'b11, c[0]};
      oe_out <= (w == 4) ? {4{drv}} : (w == 2) ? {2'b10, drv, drv} : 4'b1001;
      tick(8);
      sck_out <= 1'b1;
      rx = 8'((rx << w) | (lane_in & 4'((1 << w) - 1)));
      if (w == 1)
        rx[0] = lane_in[1];
      tick(8);
      sck_out <= 1'b0;
    end
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// ===== sim/tb.sv
// self-checking bench for the serial sram slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (e)); end end
module tb;
  import sram_slave_pkg::*;
  // small store keeps the rollover short
  localparam int AW = 8;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic cs_n;
  logic sck;
  logic [3:0] h_d;
  logic [3:0] h_oe;
  logic [3:0] d_o;
  logic [3:0] d_oe;
  wire [3:0] lane;
  logic [7:0] rx;
  int fails = 0;
  int tests_run = 0;

  always #2.5 clk_in = ~clk_in;

  // wire level: device, then host, else board pull-up
  for (genvar i = 0; i < 4; i++)
  begin : g_wire
    assign lane[i] = d_oe[i] ? d_o[i] : (h_oe[i] ? h_d[i] : 1'b1);
  end

  spi_host_model i_host (.clk_in(clk_in), .lane_in(lane), .cs_n_out(cs_n),
    .sck_out(sck), .d_out(h_d), .oe_out(h_oe));

  serial_sram_multi_io_slave #(.AW(AW)) i_dut (.clk_in(clk_in),
    .nrst_in(nrst_in), .cs_n_in(cs_n), .sck_in(sck),
    .io_lane0_in(lane[0]), .io_lane0_out(d_o[0]), .io_lane0_oe_out(d_oe[0]),
    .io_lane1_in(lane[1]), .io_lane1_out(d_o[1]), .io_lane1_oe_out(d_oe[1]),
    .io_lane2_in(lane[2]), .io_lane2_out(d_o[2]), .io_lane2_oe_out(d_oe[2]),
    .io_lane3_in(lane[3]), .io_lane3_out(d_o[3]), .io_lane3_oe_out(d_oe[3]));

  ////////////////////////////////////////
  task automatic sh(input logic [7:0] t, input int w, input logic d);
    i_host.xfer(t, w, d, rx);
  endtask : sh

  // opcode then address; upper address byte is junk on purpose
  task automatic op(input logic [7:0] c, input logic [7:0] a, input int w);
    i_host.sel(1'b0);
    sh(c, w, 1'b1);
    sh(8'hfe, w, 1'b1);
    sh(8'h00, w, 1'b1);
    sh(a, w, 1'b1);
  endtask : op

  task automatic wr(input logic [7:0] a, input int n, input logic [7:0] v, input int w);
    op(CMD_WRITE, a, w);
    for (int i = 0; i < n; i++)
      sh(v + 8'(i), w, 1'b1);
    i_host.sel(1'b1);
  endtask : wr

  task automatic rd(input logic [7:0] a, input int n, input logic [7:0] v, input int w);
    op(CMD_READ, a, w);
    if (w == 2)
      sh(8'h00, w, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      sh(8'h00, w, 1'b0);
      `CHK(rx, v + 8'(i))
    end
    i_host.sel(1'b1);
  endtask : rd

  task automatic mode(input logic [7:0] c, input logic [7:0] m);
    i_host.sel(1'b0);
    sh(c, 1, 1'b1);
    sh(m, 1, c == WRITE_MODE_REG_CMD);
    if (c == READ_MODE_REG_CMD)
      `CHK(rx, m)
    i_host.sel(1'b1);
  endtask : mode

  task automatic lanes(input logic [7:0] c, input int w);
    i_host.sel(1'b0);
    sh(c, w, 1'b1);
    i_host.sel(1'b1);
  endtask : lanes

  ////////////////////////////////////////
  task automatic t_seq;
    `CHK(d_oe, 4'h0)
    mode(READ_MODE_REG_CMD, 8'h40);
    wr(8'hfe, 3, 8'ha0, 1);
    rd(8'hfe, 3, 8'ha0, 1);
    i_host.tick(4);
    `CHK(d_oe, 4'h0)
  endtask : t_seq

  task automatic t_page;
    mode(WRITE_MODE_REG_CMD, 8'h80);
    mode(READ_MODE_REG_CMD, 8'h80);
    wr(8'h1f, 2, 8'h60, 1);
    rd(8'h1f, 2, 8'h60, 1);
    mode(WRITE_MODE_REG_CMD, 8'h00);
    op(CMD_READ, 8'h1f, 1);
    sh(8'h00, 1, 1'b0);
    `CHK(rx, 8'h60)
    i_host.tick(5);
    `CHK(d_oe[1], 1'b0)
    i_host.sel(1'b1);
    mode(WRITE_MODE_REG_CMD, 8'h40);
  endtask : t_page

  // clocks sent while paused must not move the sequence
  task automatic t_pause;
    op(CMD_READ, 8'hfe, 1);
    sh(8'h00, 1, 1'b0);
    i_host.hold(1'b0);
    `CHK(d_oe[1], 1'b0)
    sh(8'h00, 1, 1'b1);
    i_host.hold(1'b1);
    `CHK(d_oe[1], 1'b1)
    sh(8'h00, 1, 1'b0);
    `CHK(rx, 8'ha1)
    i_host.sel(1'b1);
  endtask : t_pause

  // quad data drives lane 3 low, which must not pause
  task automatic t_multi;
    lanes(ENTER_DUAL_CMD, 1);
    wr(8'h10, 2, 8'hc5, 2);
    rd(8'h10, 2, 8'hc5, 2);
    lanes(EXIT_MULTI_LANE_CMD, 2);
    rd(8'h10, 2, 8'hc5, 1);
    lanes(ENTER_QUAD_CMD, 1);
    wr(8'h20, 2, 8'h37, 4);
    rd(8'h20, 2, 8'h37, 4);
    lanes(EXIT_MULTI_LANE_CMD, 4);
    rd(8'h20, 2, 8'h37, 1);
  endtask : t_multi

  // a write cut short inside its address is dropped
  task automatic t_abort;
    i_host.sel(1'b0);
    sh(CMD_WRITE, 1, 1'b1);
    sh(8'hfe, 1, 1'b1);
    i_host.sel(1'b1);
    mode(READ_MODE_REG_CMD, 8'h40);
    rd(8'h10, 1, 8'hc5, 1);
  endtask : t_abort

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish

  // every wait above is a fixed count, so no hang is possible
  initial
  begin
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    t_seq();
    t_page();
    t_pause();
    t_multi();
    t_abort();
    tally_and_finish();
  end
endmodule : tb
`default_nettype wire
